// ### rtl/tiop_pkg.sv
package tiop_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int XFER_W = 32;
    localparam int CNT_W  = 16;
    localparam int DIV_W  = 8;
    localparam int CBLK_N = 6;
    localparam int CBSEL_W = 3;
    localparam int SLOT_W = 6;

    // Register offsets, one aligned word each
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_OUTDATA = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_INDATA  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COND    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_TIME    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_COUNT   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STAMP   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_CLKCFG  = 8'h20;
    localparam logic [ADDR_W-1:0] CLKCFG_STEP = 8'h04;

    // Control register fields
    localparam int C_DIR    = 0;
    localparam int C_OD     = 1;
    localparam int C_COND   = 2;
    localparam int C_NEQ    = 3;
    localparam int C_SIN    = 4;
    localparam int C_SOUT   = 5;
    localparam int C_CB_LSB = 6;
    localparam int C_CB_MSB = 8;
    localparam int C_EN     = 9;
    localparam int C_EV     = 10;
    localparam int CTRL_W   = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

    // Clock block config: bit 0 source, bits DIV_W:1 divider
    localparam int CB_SRC     = 0;
    localparam int CB_DIV_LSB = 1;
    localparam int CB_W       = DIV_W + 1;
    localparam logic [CB_W-1:0] CB_RST = 9'h000;

    // Status fields
    localparam int S_TXF = 0;
    localparam int S_RXV = 1;
    localparam int S_ARM = 2;
endpackage : tiop_pkg

// ### rtl/tiop_clkblk.sv
`timescale 1ns/1ns
module tiop_clkblk #(
    parameter int DIV_W = tiop_pkg::DIV_W
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             src_pin_i,
    input  wire logic [DIV_W-1:0] div_i,
    input  wire logic             ext_rise_i,
    output logic                  tick_o
);
    logic [DIV_W-1:0] cnt_r;
    logic             tick_r;
    logic             src_ev;

    // A pin source counts its rising edges, the reference counts every cycle
    assign src_ev = src_pin_i ? ext_rise_i : 1'b1;
    assign tick_o = tick_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (src_ev && cnt_r >= div_i) begin
            cnt_r  <= '0;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= src_ev ? cnt_r + 1'b1 : cnt_r;
            tick_r <= 1'b0;
        end
    end
endmodule : tiop_clkblk

// ### rtl/tiop_port.sv
`timescale 1ns/1ns
// Behaviour
// - Port width is a parameter taking 1, 4, 8, 16 or 32 bits.
// - All pins of the port are inputs or all are outputs.
// - Port drives pins high or low, or samples them, optionally on a condition.
// - Every register access completes in one cycle.
// - Open-drain mode drives zeros low and floats ones.
// - Data passes through a shift register and a transfer register.
// - A 16-bit counter times the move between pins and transfer register.
// - Counter readable anytime; transfers may wait for a set counter value.
// - Each transfer saves the counter as a timestamp.
// - An enabled link sharing the pins disables the port drivers.
// - Pins taken by a narrower enabled port are released by this one.
// - Port shifts data at its full width; pins taken by another port are not driven.
// - Six clock blocks; block 0 runs at the 100 MHz reference.
// - A clock block may use a 1-bit pin as source, optionally divided.
// - Input strobe qualifies incoming data; output strobe accompanies output.
// - After reset the port uses clock block 0.
// - Pin activity is signalled to the core as an event, not an interrupt.
// - Pull-downs are enabled while in reset.
module tiop_port #(
    parameter int PORT_W = 8,
    parameter int XFER_W = tiop_pkg::XFER_W
) (
    input  wire logic                        ref_clk_i,
    input  wire logic                        rstn_i,
    input  wire logic [tiop_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [tiop_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [tiop_pkg::DATA_W-1:0] rdata_o,
    input  wire logic [PORT_W-1:0]           pin_i,
    output logic      [PORT_W-1:0]           pin_o,
    output logic      [PORT_W-1:0]           pin_oe_o,
    output logic                             pull_down_o,
    input  wire logic                        input_valid_strobe_i,
    output logic                             output_valid_strobe_o,
    input  wire logic                        ext_clk_i,
    input  wire logic                        link_en_i,
    input  wire logic [PORT_W-1:0]           pin_taken_i,
    output logic                             event_o
);
    localparam int SLOTS = XFER_W / PORT_W;
    localparam int SYW   = PORT_W + 2;
    localparam logic [tiop_pkg::SLOT_W-1:0] LAST_SLOT = tiop_pkg::SLOT_W'(SLOTS - 1);

    function automatic logic hit(input logic [tiop_pkg::ADDR_W-1:0] a, input logic [tiop_pkg::ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    logic [SYW-1:0]                sy1_r;
    logic [SYW-1:0]                sy2_r;
    logic                          ext_d_r;
    logic [tiop_pkg::CTRL_W-1:0]   ctrl_r;
    logic [tiop_pkg::CB_W-1:0]     cbcfg_r [tiop_pkg::CBLK_N];
    logic [XFER_W-1:0]             tx_r;
    logic                          tx_full_r;
    logic [XFER_W-1:0]             rx_r;
    logic                          rx_valid_r;
    logic [PORT_W-1:0]             cond_r;
    logic [tiop_pkg::CNT_W-1:0]    time_r;
    logic                          armed_r;
    logic [tiop_pkg::CNT_W-1:0]    count_r;
    logic [tiop_pkg::CNT_W-1:0]    stamp_r;
    logic [XFER_W-1:0]             sh_r;
    logic [tiop_pkg::SLOT_W-1:0]   slot_r;
    logic [PORT_W-1:0]             pin_out_r;
    logic                          strobe_r;
    logic                          pd_r;
    logic [tiop_pkg::DATA_W-1:0]   rdata_r;
    logic [tiop_pkg::DATA_W-1:0]   rd_mux;
    logic [tiop_pkg::CBLK_N-1:0]   tick_v;
    logic [XFER_W+PORT_W-1:0]      cat_in;
    logic [PORT_W-1:0]             pin_s;
    logic                          stb_s;
    logic                          ext_rise;
    logic [tiop_pkg::CBSEL_W-1:0]  cb_sel;
    logic                          tick;
    logic                          dir_out;
    logic                          od;
    logic                          time_ok;
    logic                          cond_ok;
    logic                          samp_ok;
    logic                          start_w;
    logic                          xfer_w;
    logic                          shift_w;
    logic                          drive_en;

    // Pins, strobe and external clock cross into the reference domain
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            sy1_r   <= '0;
            sy2_r   <= '0;
            ext_d_r <= 1'b0;
        end else begin
            sy1_r   <= {ext_clk_i, input_valid_strobe_i, pin_i};
            sy2_r   <= sy1_r;
            ext_d_r <= sy2_r[PORT_W+1];
        end
    end

    assign pin_s    = sy2_r[PORT_W-1:0];
    assign stb_s    = sy2_r[PORT_W];
    assign ext_rise = sy2_r[PORT_W+1] & ~ext_d_r;
    assign dir_out  = ctrl_r[tiop_pkg::C_DIR];
    assign od       = ctrl_r[tiop_pkg::C_OD];
    assign cb_sel   = ctrl_r[tiop_pkg::C_CB_MSB:tiop_pkg::C_CB_LSB];

    // Block 0 is pinned to the undivided reference clock
    for (genvar g = 0; g < tiop_pkg::CBLK_N; g++) begin : g_cb
        tiop_clkblk #(.DIV_W(tiop_pkg::DIV_W)) u_cb (
            .ref_clk_i  (ref_clk_i),
            .rstn_i     (rstn_i),
            .src_pin_i  (g == 0 ? 1'b0 : cbcfg_r[g][tiop_pkg::CB_SRC]),
            .div_i      (g == 0 ? '0 : cbcfg_r[g][tiop_pkg::CB_W-1:tiop_pkg::CB_DIV_LSB]),
            .ext_rise_i (ext_rise),
            .tick_o     (tick_v[g])
        );
    end

    // Out-of-range selections stall the port rather than read an unknown
    assign tick = (cb_sel < tiop_pkg::CBSEL_W'(tiop_pkg::CBLK_N)) ? tick_v[cb_sel] : 1'b0;

    assign time_ok = !armed_r || (count_r == time_r);
    assign cond_ok = !ctrl_r[tiop_pkg::C_COND] || ((pin_s != cond_r) == ctrl_r[tiop_pkg::C_NEQ]);
    assign samp_ok = (!ctrl_r[tiop_pkg::C_SIN] || stb_s) && (slot_r != '0 || (cond_ok && time_ok));
    assign start_w = tick && (dir_out ? (slot_r == '0 && tx_full_r && time_ok) : (samp_ok && slot_r == '0));
    assign xfer_w  = dir_out ? start_w : (tick && samp_ok && slot_r == LAST_SLOT);
    assign shift_w = tick && dir_out && slot_r != '0;
    assign cat_in  = {pin_s, sh_r};

    // Register writes
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ctrl_r <= tiop_pkg::CTRL_RST;
            cond_r <= '0;
            time_r <= '0;
            tx_r   <= '0;
        end else if (wr_i) begin
            if (hit(addr_i, tiop_pkg::OFF_CTRL)) begin
                ctrl_r <= wdata_i[tiop_pkg::CTRL_W-1:0];
            end
            if (hit(addr_i, tiop_pkg::OFF_COND)) begin
                cond_r <= wdata_i[PORT_W-1:0];
            end
            if (hit(addr_i, tiop_pkg::OFF_TIME)) begin
                time_r <= wdata_i[tiop_pkg::CNT_W-1:0];
            end
            if (hit(addr_i, tiop_pkg::OFF_OUTDATA)) begin
                tx_r <= wdata_i[XFER_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        for (int k = 0; k < tiop_pkg::CBLK_N; k++) begin
            if (!rstn_i) begin
                cbcfg_r[k] <= tiop_pkg::CB_RST;
            end else if (wr_i && hit(addr_i, tiop_pkg::OFF_CLKCFG + tiop_pkg::ADDR_W'(k) * tiop_pkg::CLKCFG_STEP)) begin
                cbcfg_r[k] <= wdata_i[tiop_pkg::CB_W-1:0];
            end
        end
    end

    // Flags: a set (register write or hardware) in the same cycle as the clear wins
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            tx_full_r  <= 1'b0;
            rx_valid_r <= 1'b0;
            armed_r    <= 1'b0;
        end else begin
            if (wr_i && hit(addr_i, tiop_pkg::OFF_OUTDATA)) begin
                tx_full_r <= 1'b1;
            end else if (start_w && dir_out) begin
                tx_full_r <= 1'b0;
            end
            if (xfer_w && !dir_out) begin
                rx_valid_r <= 1'b1;
            end else if (rd_i && hit(addr_i, tiop_pkg::OFF_INDATA)) begin
                rx_valid_r <= 1'b0;
            end
            if (wr_i && hit(addr_i, tiop_pkg::OFF_TIME)) begin
                armed_r <= 1'b1;
            end else if (start_w) begin
                armed_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            count_r <= '0;
            stamp_r <= '0;
        end else begin
            count_r <= tick ? count_r + 1'b1 : count_r;
            if (xfer_w) begin
                stamp_r <= count_r;
            end
        end
    end

    // Serialiser: the transfer register moves one port-width slot per tick
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            sh_r      <= '0;
            slot_r    <= '0;
            pin_out_r <= '0;
            rx_r      <= '0;
            strobe_r  <= 1'b0;
        end else begin
            strobe_r <= (start_w && dir_out || shift_w) && ctrl_r[tiop_pkg::C_SOUT];
            if (dir_out && start_w) begin
                pin_out_r <= tx_r[PORT_W-1:0];
                sh_r      <= tx_r >> PORT_W;
                slot_r    <= LAST_SLOT;
            end else if (shift_w) begin
                pin_out_r <= sh_r[PORT_W-1:0];
                sh_r      <= sh_r >> PORT_W;
                slot_r    <= slot_r - 1'b1;
            end else if (!dir_out && tick && samp_ok) begin
                sh_r   <= cat_in[XFER_W+PORT_W-1:PORT_W];
                slot_r <= (slot_r == LAST_SLOT) ? '0 : slot_r + 1'b1;
                if (slot_r == LAST_SLOT) begin
                    rx_r <= cat_in[XFER_W+PORT_W-1:PORT_W];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        pd_r <= !rstn_i;
    end

    // Pin drivers
    assign drive_en    = ctrl_r[tiop_pkg::C_EN] && dir_out && !link_en_i;
    assign pin_oe_o    = drive_en ? ((od ? ~pin_out_r : '1) & ~pin_taken_i) : '0;
    assign pin_o       = od ? '0 : pin_out_r;
    assign pull_down_o = pd_r | ~rstn_i;
    assign output_valid_strobe_o = strobe_r;
    assign event_o = ctrl_r[tiop_pkg::C_EV] && (dir_out ? !tx_full_r : rx_valid_r);

    // Read path: data in the cycle after the strobe, zero otherwise
    always_comb begin
        rd_mux = '0;
        case (addr_i)
            tiop_pkg::OFF_CTRL:   rd_mux = tiop_pkg::DATA_W'(ctrl_r);
            tiop_pkg::OFF_INDATA: rd_mux = tiop_pkg::DATA_W'(rx_r);
            tiop_pkg::OFF_COND:   rd_mux = tiop_pkg::DATA_W'(cond_r);
            tiop_pkg::OFF_TIME:   rd_mux = tiop_pkg::DATA_W'(time_r);
            tiop_pkg::OFF_COUNT:  rd_mux = tiop_pkg::DATA_W'(count_r);
            tiop_pkg::OFF_STAMP:  rd_mux = tiop_pkg::DATA_W'(stamp_r);
            tiop_pkg::OFF_STATUS: rd_mux = tiop_pkg::DATA_W'({armed_r, rx_valid_r, tx_full_r});
            default:              rd_mux = '0;
        endcase
        for (int k = 0; k < tiop_pkg::CBLK_N; k++) begin
            if (hit(addr_i, tiop_pkg::OFF_CLKCFG + tiop_pkg::ADDR_W'(k) * tiop_pkg::CLKCFG_STEP)) begin
                rd_mux = tiop_pkg::DATA_W'(cbcfg_r[k]);
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rd_i ? rd_mux : '0;
        end
    end

    assign rdata_o = rdata_r;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    pull_reset_a: assert property (disable iff (1'b0) !rstn_i |-> pull_down_o)
        else $error("pull-down not active in reset");
    od_low_a: assert property (od |-> (pin_o == '0) && ((pin_oe_o & pin_out_r) == '0))
        else $error("open-drain drives a one");
    link_off_a: assert property (link_en_i |-> pin_oe_o == '0)
        else $error("pins driven while link enabled");
    taken_pins_a: assert property ((pin_oe_o & pin_taken_i) == '0)
        else $error("pin driven that a narrower port owns");
    input_dir_a: assert property (!dir_out |-> pin_oe_o == '0)
        else $error("input port drives pins");
    count_step_a: assert property (tick |=> count_r == $past(count_r) + 1'b1)
        else $error("counter did not step on tick");
    stamp_cap_a: assert property (xfer_w |=> stamp_r == $past(count_r))
        else $error("timestamp not captured");
    timed_xfer_a: assert property (start_w && armed_r |-> count_r == time_r)
        else $error("timed transfer at wrong count");
    reset_block_a: assert property ($rose(rstn_i) |-> cb_sel == '0)
        else $error("clock block not 0 after reset");
    read_count_a: assert property (rd_i && addr_i == tiop_pkg::OFF_COUNT |=> rdata_o == 32'($past(count_r)))
        else $error("counter read mismatch");
    strobe_out_a: assert property (output_valid_strobe_o |-> $past(ctrl_r[tiop_pkg::C_SOUT]) && $past(tick))
        else $error("output strobe without data");
    cond_wait_a: assert property (!dir_out && start_w && ctrl_r[tiop_pkg::C_COND] |-> cond_ok)
        else $error("sample taken before condition held");

    out_xfer_c: cover property (dir_out && start_w ##[1:40] dir_out && start_w);
    in_word_c: cover property (!dir_out && xfer_w);
    timed_c: cover property (armed_r && start_w);
    cond_c: cover property (ctrl_r[tiop_pkg::C_COND] && !dir_out && xfer_w);
endmodule : tiop_port

// ### verif/tiop_pin_model.sv
`timescale 1ns/1ns
// External hardware on the port pins: pin drivers, input strobe, pin clock
module tiop_pin_model #(
    parameter int PORT_W = 8
) (
    input  wire logic              ref_clk_i,
    input  wire logic [PORT_W-1:0] pin_o_i,
    input  wire logic [PORT_W-1:0] pin_oe_i,
    input  wire logic              pull_down_i,
    output logic      [PORT_W-1:0] pin_level_o,
    output logic                   strobe_o,
    output logic                   ext_clk_o
);
    logic [PORT_W-1:0] ext_val_r;
    logic [PORT_W-1:0] ext_en_r;
    logic [PORT_W-1:0] float_r = '0;

    initial begin
        ext_val_r = '0;
        ext_en_r  = '0;
        strobe_o  = 1'b0;
        ext_clk_o = 1'b0;
    end

    // Undriven, unpulled pins toggle so a stale value never reads as valid
    always_ff @(posedge ref_clk_i) begin
        float_r <= ~float_r;
    end

    // Wire level from port drive, external drive and pull-downs
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (pin_oe_i[i]) begin
                pin_level_o[i] = pin_o_i[i];
            end else if (ext_en_r[i]) begin
                pin_level_o[i] = ext_val_r[i];
            end else if (pull_down_i) begin
                pin_level_o[i] = 1'b0;
            end else begin
                pin_level_o[i] = float_r[i];
            end
        end
    end

    task automatic drive(input logic [PORT_W-1:0] v, input logic [PORT_W-1:0] en);
        @(posedge ref_clk_i);
        ext_val_r <= v;
        ext_en_r  <= en;
    endtask : drive

    // Data settles before the strobe and holds past it
    task automatic send(input logic [PORT_W-1:0] v);
        drive(v, '1);
        repeat (2) @(posedge ref_clk_i);
        strobe_o <= 1'b1;
        @(posedge ref_clk_i);
        strobe_o <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask : send

    // Pin clock runs only while a burst is asked for
    task automatic ext_pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge ref_clk_i);
            ext_clk_o <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            ext_clk_o <= 1'b0;
        end
    endtask : ext_pulses
endmodule : tiop_pin_model

// ### verif/timed_io_port_with_clocking_tb_top.sv
`timescale 1ns/1ns
module timed_io_port_with_clocking_tb_top;
    logic        ref_clk_i;
    logic        rstn_i;
    logic        wr_i;
    logic        rd_i;
    logic        link_en_i;
    logic [7:0]  addr_i;
    logic [7:0]  taken;
    logic [7:0]  pin_in;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe;
    logic [31:0] wdata_i;
    logic [31:0] rdata_o;
    logic [31:0] v;
    logic [31:0] c0;
    logic [31:0] c1;
    logic        pull_down;
    logic        s_in;
    logic        s_out;
    logic        ext_clk;
    logic        event_w;
    int          failures;
    int          tests_run;

    tiop_port #(.PORT_W(8)) dut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pin_i(pin_in), .pin_o(pin_o), .pin_oe_o(pin_oe), .pull_down_o(pull_down),
        .input_valid_strobe_i(s_in), .output_valid_strobe_o(s_out), .ext_clk_i(ext_clk),
        .link_en_i(link_en_i), .pin_taken_i(taken), .event_o(event_w)
    );

    tiop_pin_model #(.PORT_W(8)) u_pins (
        .ref_clk_i(ref_clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pull_down_i(pull_down),
        .pin_level_o(pin_in), .strobe_o(s_in), .ext_clk_o(ext_clk)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic wrap_up();
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    // Bounded wait for an output slot; running out ends the run
    task automatic wait_so(input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge ref_clk_i);
            #1;
            if (s_out === 1'b1) break;
        end
        if (i == lim) begin
            failures++;
            wrap_up();
        end
    endtask : wait_so

    task automatic run_out(input logic od);
        logic [31:0] d;
        d = $urandom();
        wr(tiop_pkg::OFF_CTRL, 32'h0000_0221 | {30'h0, od, 1'b0});
        rd(tiop_pkg::OFF_COUNT, c0);
        wr(tiop_pkg::OFF_OUTDATA, d);
        wait_so(10);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) begin
                @(posedge ref_clk_i);
                #1;
            end
            chk("out_strobe", s_out, 32'h1);
            chk("pin_o", pin_o, od ? 8'h00 : d[8*k+:8]);
            chk("pin_oe", pin_oe, od ? 8'(~d[8*k+:8]) : 8'hFF);
        end
        @(posedge ref_clk_i);
        #1 chk("out_strobe_end", s_out, 32'h0);
        rd(tiop_pkg::OFF_STAMP, v);
        chk("stamp", v, {16'h0, c0[15:0] + 16'h0003});
    endtask : run_out

    initial begin
        logic [7:0] b [4];
        logic [7:0] pre;
        logic [7:0] post;
        failures  = 0;
        tests_run = 0;
        rstn_i    = 1'b0;
        wr_i      = 1'b0;
        rd_i      = 1'b0;
        link_en_i = 1'b0;
        taken     = 8'h00;
        addr_i    = 8'h00;
        wdata_i   = 32'h0;
        void'($urandom(32'h82BFE309));
        repeat (2) @(posedge ref_clk_i);
        #1 chk("pull_down_rst", pull_down, 32'h1);
        chk("oe_rst", pin_oe, 32'h0);
        @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        rd(tiop_pkg::OFF_CTRL, v);
        chk("ctrl_rst", v, 32'h0);
        chk("pull_down_run", pull_down, 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, v);
        chk("unmapped", v, 32'h0);
        rd(tiop_pkg::OFF_COUNT, c0);
        rd(tiop_pkg::OFF_COUNT, c1);
        chk("count_rate", {16'h0, c1[15:0] - c0[15:0]}, 32'h2);
        run_out(1'b0);
        run_out(1'b1);
        run_out(1'b0);
        v = $urandom();
        @(posedge ref_clk_i);
        taken <= v[7:0];
        #1 chk("oe_taken", pin_oe, {24'h0, ~v[7:0]});
        @(posedge ref_clk_i);
        link_en_i <= 1'b1;
        #1 chk("oe_link", pin_oe, 32'h0);
        @(posedge ref_clk_i);
        link_en_i <= 1'b0;
        taken     <= 8'h00;
        // Timed transfer waits for the counter; its stamp is the set time
        wr(tiop_pkg::OFF_CTRL, 32'h0000_0221);
        rd(tiop_pkg::OFF_COUNT, c0);
        wr(tiop_pkg::OFF_TIME, {16'h0, c0[15:0] + 16'h001E});
        rd(tiop_pkg::OFF_STATUS, v);
        chk("armed", v[tiop_pkg::S_ARM], 32'h1);
        wr(tiop_pkg::OFF_OUTDATA, $urandom());
        wait_so(60);
        rd(tiop_pkg::OFF_STAMP, v);
        chk("timed_stamp", v, {16'h0, c0[15:0] + 16'h001E});
        // Strobed input with event to the core
        wr(tiop_pkg::OFF_CTRL, 32'h0000_0610);
        rd(tiop_pkg::OFF_INDATA, v);
        chk("event_idle", event_w, 32'h0);
        for (int k = 0; k < 4; k++) begin
            b[k] = 8'($urandom());
            u_pins.send(b[k]);
        end
        repeat (3) @(posedge ref_clk_i);
        #1 chk("event_rx", event_w, 32'h1);
        rd(tiop_pkg::OFF_INDATA, v);
        chk("indata", v, {b[3], b[2], b[1], b[0]});
        chk("event_clr", event_w, 32'h0);
        // Conditional sampling, equal then not-equal sense
        for (int s = 0; s < 2; s++) begin
            pre  = (s == 1) ? 8'h5A : 8'h33;
            post = (s == 1) ? 8'h33 : 8'h5A;
            wr(tiop_pkg::OFF_CTRL, 32'h0);
            u_pins.drive(pre, 8'hFF);
            wr(tiop_pkg::OFF_COND, 32'h0000_005A);
            wr(tiop_pkg::OFF_CTRL, 32'h0000_0204 | (s << 3));
            // A word already under way still completes; clear it before checking the wait
            repeat (8) @(posedge ref_clk_i);
            rd(tiop_pkg::OFF_INDATA, v);
            repeat (12) @(posedge ref_clk_i);
            rd(tiop_pkg::OFF_STATUS, v);
            chk("cond_wait", v[tiop_pkg::S_RXV], 32'h0);
            u_pins.drive(post, 8'hFF);
            repeat (12) @(posedge ref_clk_i);
            rd(tiop_pkg::OFF_INDATA, v);
            chk("cond_data", v, {4{post}});
        end
        // Clock block 1 from the pin clock, divided by two
        wr(tiop_pkg::OFF_CLKCFG + tiop_pkg::CLKCFG_STEP, 32'h0000_0003);
        wr(tiop_pkg::OFF_CTRL, 32'h0000_0240);
        rd(tiop_pkg::OFF_COUNT, c0);
        u_pins.ext_pulses(10);
        repeat (6) @(posedge ref_clk_i);
        rd(tiop_pkg::OFF_COUNT, c1);
        chk("ext_count", {16'h0, c1[15:0] - c0[15:0]}, 32'h5);
        wrap_up();
    end
endmodule : timed_io_port_with_clocking_tb_top
